// ---- rtl/sss_pkg.sv ----
// shared constants and types for the simultaneous sampling sequencer
package sss_pkg;

    // ==========================================================
    // bus and register map
    localparam int APB_AW = 12;
    localparam logic [APB_AW-1:0] CTRL1_ADDR = 12'h000;
    localparam logic [APB_AW-1:0] CTRL2_ADDR = 12'h004;
    localparam logic [APB_AW-1:0] STATUS_ADDR = 12'h008;
    localparam logic [APB_AW-1:0] MASK_ADDR = 12'h00c;
    localparam logic [APB_AW-1:0] RESULT_BASE = 12'h040;
    localparam logic [APB_AW-1:0] RESULT_END = 12'h07c;

    // ==========================================================
    // field positions
    localparam int C1_SIMULTANEOUS_MODE_SELECT_BIT = 0;
    localparam int C1_CONT_BIT = 1;
    localparam int C1_EV1_EN_BIT = 4;
    localparam int C1_EV2_EN_BIT = 5;
    localparam int C1_EXT_EN_BIT = 6;
    localparam int C1_ACQ_LSB = 8;
    localparam int C1_CHAN_LSB = 12;
    localparam int C2_SW_START_BIT = 0;
    localparam int ST_FLAG_A_BIT = 0;
    localparam int ST_FLAG_B_BIT = 1;
    localparam int ST_BUSY_BIT = 8;
    localparam int ST_PTR_LSB = 12;
    localparam logic [15:0] CTRL1_RESET = 16'h0000;
    localparam logic [1:0] MASK_RESET = 2'h0;

    // ==========================================================
    // result store
    localparam int RES_W = 12;
    localparam int SLOT_AW = 4;
    localparam int SLOT_N = 16;

    // ==========================================================
    // timing: converter clock derived from the system clock
    localparam longint SYS_CLK_HZ = 10_000_000;
    localparam longint CONV_CLK_HZ = 5_000_000;
    localparam int HALF_TICKS = int'(SYS_CLK_HZ / (2 * CONV_CLK_HZ));
    localparam logic [7:0] CONV_CYC = 8'(2 * HALF_TICKS);
    localparam int TRIG_DLY_HALVES = 5;
    localparam logic [7:0] TRIG_DLY_CYC = 8'(TRIG_DLY_HALVES * HALF_TICKS);
    localparam logic [7:0] SH_BASE_CLK = 8'h01;
    localparam logic [7:0] FIRST_A_CLK = 8'h04;
    localparam logic [7:0] FIRST_B_CLK = 8'h05;
    localparam logic [7:0] SUCC_SIM_CLK = 8'h03;
    localparam logic [7:0] SUCC_SEQ_CLK = 8'h02;
    localparam int FLAG_DLY = 2;

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DELAY = 2'b01,
        ST_HOLD = 2'b10,
        ST_CONV = 2'b11
    } sss_state_e;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [APB_AW-1:0] paddr;
        logic [31:0] pwdata;
    } sss_apb_req_s;

    typedef struct packed {
        logic [RES_W-1:0] a;
        logic [RES_W-1:0] b;
    } sss_sample_s;

endpackage : sss_pkg

// ---- rtl/sss_result_mem.sv ----
// result slot memory with registered read data
`timescale 1ns/1ns
module sss_result_mem (
    input wire logic sys_clk_i,
    input wire logic wr_en_i,
    input wire logic [sss_pkg::SLOT_AW-1:0] wr_addr_i,
    input wire logic [sss_pkg::RES_W-1:0] wr_data_i,
    input wire logic [sss_pkg::SLOT_AW-1:0] rd_addr_i,
    output logic [sss_pkg::RES_W-1:0] rd_data_o
);
    import sss_pkg::*;

    logic [RES_W-1:0] mem_reg [SLOT_N];

    // no reset on the array: contents are undefined until first conversion
    always_ff @(posedge sys_clk_i) begin
        if (wr_en_i) begin
            mem_reg[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem_reg[rd_addr_i];
    end

endmodule : sss_result_mem

// ---- rtl/sss_top.sv ----
// sampling sequencer: triggers, sample/hold timing, result slots, flags, apb slave
`timescale 1ns/1ns
// Functional notes
// R1 - with simultaneous mode set, convert both pair channels each pulse; continuous allowed
// R2 - any one of eight like-numbered A/B channel pairs is selectable
// R3 - software selects only like-numbered pairs; mixed pairings are not allowed
// R4 - start comes from either event manager, software, or external start pin
// R5 - both pair channels are sampled together at the sample/hold falling edge
// R6 - sample/hold pulse lasts one to sixteen converter clocks
// R7 - sampling begins two and a half converter clocks after the trigger
// R8 - sample/hold width is one plus acquisition field, bits eight to eleven
// R9 - first sample: A result after four clocks, B result after five
// R10 - successive samples: both results after three plus acquisition field clocks; here B is written one system cycle after A
// R11 - interrupt flags set a few system cycles after result update
// R12 - simultaneous mode clear: one selected channel converted per pulse
// R13 - pair results go to adjacent slots, A written first
module sss_top (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire sss_pkg::sss_apb_req_s apb_req_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic event_manager_first_i,
    input wire logic event_manager_second_i,
    input wire logic external_conversion_start_i,
    input wire sss_pkg::sss_sample_s analog_input_channel_i,
    output logic [3:0] chan_sel_o,
    output logic sample_hold_o,
    output logic irq_o
);
    import sss_pkg::*;

    // ==========================================================
    // declarations
    sss_state_e state_reg;
    logic [15:0] ctrl1_reg;
    logic [1:0] status_reg;
    logic [1:0] mask_reg;
    logic [7:0] cnt_reg;
    logic first_reg;
    logic run_simultaneous_mode_select_reg;
    logic [3:0] run_acq_reg;
    sss_sample_s held_reg;
    logic [SLOT_AW-1:0] ptr_reg;
    logic ev1_prev_reg;
    logic ev2_prev_reg;
    logic ext_prev_reg;
    logic [FLAG_DLY-1:0] flag_a_pipe_reg;
    logic [FLAG_DLY-1:0] flag_b_pipe_reg;
    logic sw_start_reg;
    logic [RES_W-1:0] mem_rdata;
    logic access;
    logic wr_now;
    logic is_ctrl1;
    logic is_ctrl2;
    logic is_status;
    logic is_mask;
    logic is_result;
    logic mapped;
    logic trig;
    logic [7:0] sh_cyc;
    logic [7:0] lat_a;
    logic [7:0] lat_b;
    logic [7:0] last_cnt;
    logic wr_a;
    logic wr_b;
    logic mem_we;
    logic [SLOT_AW-1:0] mem_waddr;
    logic [RES_W-1:0] mem_wdata;
    logic [31:0] rd_word;

    // ==========================================================
    // apb decode
    assign access = apb_req_i.psel & apb_req_i.penable;
    assign wr_now = access & pready_o & apb_req_i.pwrite;

    always_comb begin
        is_ctrl1 = 1'b0;
        is_ctrl2 = 1'b0;
        is_status = 1'b0;
        is_mask = 1'b0;
        is_result = 1'b0;
        if (apb_req_i.paddr == CTRL1_ADDR) begin
            is_ctrl1 = 1'b1;
        end else if (apb_req_i.paddr == CTRL2_ADDR) begin
            is_ctrl2 = 1'b1;
        end else if (apb_req_i.paddr == STATUS_ADDR) begin
            is_status = 1'b1;
        end else if (apb_req_i.paddr == MASK_ADDR) begin
            is_mask = 1'b1;
        end else if (apb_req_i.paddr >= RESULT_BASE && apb_req_i.paddr <= RESULT_END
                     && apb_req_i.paddr[1:0] == 2'h0) begin
            is_result = 1'b1;
        end
    end

    assign mapped = is_ctrl1 | is_ctrl2 | is_status | is_mask | is_result;

    always_comb begin
        rd_word = 32'h0000_0000;
        if (is_ctrl1) begin
            rd_word = {16'h0000, ctrl1_reg};
        end else if (is_status) begin
            rd_word[ST_FLAG_B_BIT:ST_FLAG_A_BIT] = status_reg;
            rd_word[ST_BUSY_BIT] = (state_reg != ST_IDLE);
            rd_word[ST_PTR_LSB +: SLOT_AW] = ptr_reg;
        end else if (is_mask) begin
            rd_word[1:0] = mask_reg;
        end else if (is_result) begin
            rd_word[RES_W-1:0] = mem_rdata;
        end
    end

    // ==========================================================
    // apb answer: one wait state so the slot memory read settles
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end else begin
            pready_o <= access & ~pready_o;
            pslverr_o <= access & ~pready_o & ~mapped;
            if (access & ~pready_o & ~apb_req_i.pwrite) begin
                prdata_o <= rd_word;
            end
        end
    end

    // ==========================================================
    // control registers
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl1_reg <= CTRL1_RESET;
            mask_reg <= MASK_RESET;
        end else if (wr_now) begin
            if (is_ctrl1) begin
                ctrl1_reg <= apb_req_i.pwdata[15:0];
            end
            if (is_mask) begin
                mask_reg <= apb_req_i.pwdata[1:0];
            end
        end
    end

    // software start is a write-one strobe, never stored beyond one cycle
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sw_start_reg <= 1'b0;
        end else begin
            sw_start_reg <= wr_now & is_ctrl2 & apb_req_i.pwdata[C2_SW_START_BIT];
        end
    end

    // ==========================================================
    // trigger sources
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ev1_prev_reg <= 1'b0;
            ev2_prev_reg <= 1'b0;
            ext_prev_reg <= 1'b0;
        end else begin
            ev1_prev_reg <= event_manager_first_i;
            ev2_prev_reg <= event_manager_second_i;
            ext_prev_reg <= external_conversion_start_i;
        end
    end

    // rising edges only, so a held trigger level does not restart
    assign trig = sw_start_reg
        | (ctrl1_reg[C1_EV1_EN_BIT] & event_manager_first_i & ~ev1_prev_reg)
        | (ctrl1_reg[C1_EV2_EN_BIT] & event_manager_second_i & ~ev2_prev_reg)
        | (ctrl1_reg[C1_EXT_EN_BIT] & external_conversion_start_i & ~ext_prev_reg); // R4

    // ==========================================================
    // timing figures in system cycles
    assign sh_cyc = 8'((SH_BASE_CLK + {4'h0, run_acq_reg}) * CONV_CYC); // R6 R8
    always_comb begin
        if (first_reg) begin
            lat_a = 8'(FIRST_A_CLK * CONV_CYC); // R9
            lat_b = 8'(FIRST_B_CLK * CONV_CYC); // R9
        end else if (run_simultaneous_mode_select_reg) begin
            lat_a = 8'((SUCC_SIM_CLK + {4'h0, run_acq_reg}) * CONV_CYC); // R10
            lat_b = 8'(lat_a + 8'h01); // R10 R13
        end else begin
            lat_a = 8'((SUCC_SEQ_CLK + {4'h0, run_acq_reg}) * CONV_CYC);
            lat_b = lat_a;
        end
        last_cnt = run_simultaneous_mode_select_reg ? lat_b : lat_a;
    end

    assign wr_a = (state_reg == ST_CONV) && (cnt_reg == lat_a);
    assign wr_b = (state_reg == ST_CONV) && run_simultaneous_mode_select_reg && (cnt_reg == lat_b); // R1

    // ==========================================================
    // sequencer
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 8'h00;
            first_reg <= 1'b1;
            run_simultaneous_mode_select_reg <= 1'b0;
            run_acq_reg <= 4'h0;
            chan_sel_o <= 4'h0;
            sample_hold_o <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (trig) begin
                        // settings frozen for the whole run
                        run_simultaneous_mode_select_reg <= ctrl1_reg[C1_SIMULTANEOUS_MODE_SELECT_BIT]; // R1 R12
                        run_acq_reg <= ctrl1_reg[C1_ACQ_LSB +: 4]; // R8
                        chan_sel_o <= ctrl1_reg[C1_CHAN_LSB +: 4]; // R2 R3
                        first_reg <= 1'b1;
                        cnt_reg <= 8'(TRIG_DLY_CYC - 8'h01); // R7
                        state_reg <= ST_DELAY;
                    end
                end
                ST_DELAY: begin
                    if (cnt_reg == 8'h00) begin
                        sample_hold_o <= 1'b1; // R7
                        cnt_reg <= 8'(sh_cyc - 8'h01);
                        state_reg <= ST_HOLD;
                    end else begin
                        cnt_reg <= 8'(cnt_reg - 8'h01);
                    end
                end
                ST_HOLD: begin
                    if (cnt_reg == 8'h00) begin
                        sample_hold_o <= 1'b0; // R5
                        cnt_reg <= 8'h01;
                        state_reg <= ST_CONV;
                    end else begin
                        cnt_reg <= 8'(cnt_reg - 8'h01); // R6
                    end
                end
                ST_CONV: begin
                    if (cnt_reg == last_cnt) begin
                        first_reg <= 1'b0;
                        // continuous mode: next pulse starts without a trigger
                        if (ctrl1_reg[C1_CONT_BIT]) begin
                            sample_hold_o <= 1'b1; // R1
                            cnt_reg <= 8'(sh_cyc - 8'h01);
                            state_reg <= ST_HOLD;
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end else begin
                        cnt_reg <= 8'(cnt_reg + 8'h01);
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // sample capture: both channels at the same edge
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            held_reg <= '0;
        end else if (state_reg == ST_HOLD && cnt_reg == 8'h00) begin
            held_reg <= analog_input_channel_i; // R5
        end
    end

    // ==========================================================
    // result slots
    always_comb begin
        mem_we = wr_a | wr_b;
        mem_waddr = ptr_reg;
        mem_wdata = wr_a ? held_reg.a : held_reg.b; // R13
        // sequential mode takes the B input when the select names a B channel
        if (wr_a && !run_simultaneous_mode_select_reg && chan_sel_o[3]) begin
            mem_wdata = held_reg.b; // R12
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ptr_reg <= '0;
        end else if (state_reg == ST_IDLE && trig) begin
            ptr_reg <= '0;
        end else if (mem_we) begin
            ptr_reg <= SLOT_AW'(ptr_reg + 1'b1); // R13
        end
    end

    sss_result_mem u_mem (
        .sys_clk_i(sys_clk_i),
        .wr_en_i(mem_we),
        .wr_addr_i(mem_waddr),
        .wr_data_i(mem_wdata),
        .rd_addr_i(apb_req_i.paddr[2 +: SLOT_AW]),
        .rd_data_o(mem_rdata)
    );

    // ==========================================================
    // flags trail the slot write by a fixed pipe
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            flag_a_pipe_reg <= '0;
            flag_b_pipe_reg <= '0;
        end else begin
            flag_a_pipe_reg <= {flag_a_pipe_reg[FLAG_DLY-2:0], wr_a}; // R11
            flag_b_pipe_reg <= {flag_b_pipe_reg[FLAG_DLY-2:0], wr_b}; // R11
        end
    end

    // set wins over a same-cycle write-one clear
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            status_reg <= 2'h0;
        end else begin
            if (wr_now && is_status) begin
                status_reg <= status_reg & ~apb_req_i.pwdata[1:0]
                    | {flag_b_pipe_reg[FLAG_DLY-1], flag_a_pipe_reg[FLAG_DLY-1]};
            end else begin
                status_reg <= status_reg
                    | {flag_b_pipe_reg[FLAG_DLY-1], flag_a_pipe_reg[FLAG_DLY-1]}; // R11
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(status_reg & mask_reg);
        end
    end

endmodule : sss_top

// ---- test/sss_checker_assertions.sv ----
// port checker for the sampling sequencer
`timescale 1ns/1ns
module sss_checker (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire sss_pkg::sss_apb_req_s apb_req_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic [3:0] chan_sel_o,
    input wire logic sample_hold_o,
    input wire logic irq_o
);
    import sss_pkg::*;
    // ====
    // shadow of the written settings
    logic wr;
    logic odd;
    logic [11:0] a;
    logic [15:0] c1;
    logic [1:0] mk;
    logic [5:0] cnt;
    assign a = apb_req_i.paddr;
    assign wr = apb_req_i.psel & apb_req_i.penable & pready_o & apb_req_i.pwrite;
    assign odd = !(a inside {CTRL1_ADDR, CTRL2_ADDR, STATUS_ADDR, MASK_ADDR})
        && !(a >= RESULT_BASE && a <= RESULT_END && a[1:0] == 2'b00);
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            c1 <= CTRL1_RESET;
            mk <= MASK_RESET;
            cnt <= '0;
        end else begin
            cnt <= sample_hold_o ? cnt + 6'd1 : 6'd0;
            if (wr && a == CTRL1_ADDR) begin
                c1 <= apb_req_i.pwdata[15:0];
            end
            if (wr && a == MASK_ADDR) begin
                mk <= apb_req_i.pwdata[1:0];
            end
        end
    end
    // ====
    // properties
    default clocking dc @(posedge sys_clk_i);
    endclocking
    default disable iff (!reset_n_i);
    a_hold_width: assert property ($fell(sample_hold_o)
        |-> cnt == 6'(2 * (c1[11:8] + 1)))
        else $error("sample hold width wrong");
    a_ready_wait: assert property (apb_req_i.psel && !apb_req_i.penable
        |-> ##1 !pready_o ##1 pready_o)
        else $error("ready not in second access cycle");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    a_err_code: assert property (pready_o |-> pslverr_o == odd)
        else $error("error response does not match address");
    a_err_rdata: assert property (pready_o && pslverr_o && !apb_req_i.pwrite |-> prdata_o == 32'h0)
        else $error("refused read returned data");
    a_irq_masked: assert property (mk == 2'b00 && $past(mk) == 2'b00 |-> !irq_o)
        else $error("interrupt with all sources masked");
    // pair mode needs room for two slot writes, single mode only for one
    a_gap_min: assert property ($fell(sample_hold_o) && c1[C1_SIMULTANEOUS_MODE_SELECT_BIT]
        |-> !sample_hold_o [*7])
        else $error("next pulse before results stored");
    a_gap_single: assert property ($fell(sample_hold_o) && !c1[C1_SIMULTANEOUS_MODE_SELECT_BIT]
        |-> !sample_hold_o [*4])
        else $error("next single pulse before result stored");
    a_chan_held: assert property (sample_hold_o |-> $stable(chan_sel_o))
        else $error("channel moved during sampling pulse");
    a_pair_index: assert property (c1[0] && sample_hold_o |-> !chan_sel_o[3])
        else $error("pair mode selected a single b input");
    c_cont: cover property (c1[1] && $rose(sample_hold_o));
    c_irq: cover property ($rose(irq_o));
    c_err: cover property (pready_o && pslverr_o);
endmodule : sss_checker

bind sss_top sss_checker u_chk (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .apb_req_i(apb_req_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .chan_sel_o(chan_sel_o),
    .sample_hold_o(sample_hold_o),
    .irq_o(irq_o)
);

// ---- test/sss_src_model.sv ----
// trigger pins and analog pair in front of the sequencer
`timescale 1ns/1ns
module sss_src_model (
    input wire logic sys_clk_i,
    input wire logic sample_hold_i,
    input wire logic [2:0] kick_i,
    input wire logic [23:0] next_i,
    output logic [2:0] trig_o,
    output sss_pkg::sss_sample_s pair_o,
    output sss_pkg::sss_sample_s held_o
);
    import sss_pkg::*;
    logic sh_d = 1'b0;
    initial begin
        trig_o = '0;
        held_o = '0;
    end
    always @(posedge sys_clk_i) begin
        sh_d <= sample_hold_i;
        trig_o <= kick_i;
        if (sample_hold_i && !sh_d) begin
            held_o <= sss_sample_s'(next_i);
        end
    end
    // inverted outside the pulse and the cycle after it, so a sample taken at the wrong edge shows
    assign pair_o = (sample_hold_i || sh_d) ? held_o : ~held_o;
endmodule : sss_src_model

// ---- test/testbench.sv ----
// self-checking bench for the sampling sequencer
`timescale 1ns/1ns
module testbench;
    import sss_pkg::*;
    logic sys_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    sss_apb_req_s req = '0;
    logic [2:0] kick = '0;
    logic [23:0] next_v = '0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready, pslverr, sh, irq, err;
    logic [3:0] chan;
    logic [3:0] aq;
    logic [2:0] trig;
    sss_sample_s pair, held;
    int bad_count = 0;
    int n_tests = 0;
    int s, n, k;
    always #50 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) next_v <= 24'($urandom);
    sss_top u_dut (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .apb_req_i(req),
        .prdata_o(prdata),
        .pready_o(pready),
        .pslverr_o(pslverr),
        .event_manager_first_i(trig[0]),
        .event_manager_second_i(trig[1]),
        .external_conversion_start_i(trig[2]),
        .analog_input_channel_i(pair),
        .chan_sel_o(chan),
        .sample_hold_o(sh),
        .irq_o(irq)
    );
    sss_src_model u_src (
        .sys_clk_i(sys_clk_i),
        .sample_hold_i(sh),
        .kick_i(kick),
        .next_i(next_v),
        .trig_o(trig),
        .pair_o(pair),
        .held_o(held)
    );
    // ====
    // helpers
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    function automatic logic [31:0] ctl(input logic sm, input logic ct, input logic [3:0] a,
        input logic [3:0] ch);
        return {16'h0, ch, a, 1'b0, 3'b111, 2'b00, ct, sm};
    endfunction : ctl
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge sys_clk_i);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge sys_clk_i);
        req.penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge sys_clk_i);
            if (pready === 1'b1) break;
        end
        check(32'(pready), 32'h1);
        rd = prdata;
        err = pslverr;
        req <= '0;
    endtask : apb
    task automatic wait_for(input int sel, input logic lvl, output int c);
        for (c = 1; c < 300; c++) begin
            @(posedge sys_clk_i);
            if ((sel ? irq : sh) === lvl) break;
        end
    endtask : wait_for
    task automatic fire(input int src);
        if (src == 0) begin
            apb(1'b1, CTRL2_ADDR, 32'h1);
        end else begin
            kick <= 3'(1 << (src - 1));
            @(posedge sys_clk_i);
            kick <= '0;
        end
    endtask : fire
    task automatic clear_check();
        apb(1'b1, STATUS_ADDR, 32'h3);
        apb(1'b0, STATUS_ADDR, '0);
        check(32'({irq, rd[1:0]}), 32'h0);
    endtask : clear_check
    task automatic one_shot(input int src, input logic sm, input logic [3:0] ch,
        input logic [1:0] m);
        int c;
        logic [3:0] a;
        a = 4'($urandom);
        apb(1'b1, MASK_ADDR, 32'(m));
        apb(1'b1, CTRL1_ADDR, ctl(sm, 1'b0, a, ch));
        fire(src);
        wait_for(0, 1'b1, c);
        check(c, 7);
        check(32'(chan), 32'(ch));
        wait_for(0, 1'b0, c);
        check(c, 2 * (a + 1));
        wait_for(1, 1'b1, c);
        check(c, m[1] ? 13 : 11);
        apb(1'b0, STATUS_ADDR, '0);
        check(32'({rd[15:12], rd[8], rd[1:0]}), sm ? 32'h13 : 32'h09);
        apb(1'b0, RESULT_BASE, '0);
        check(rd, 32'((sm || !ch[3]) ? held.a : held.b));
        if (sm) begin
            apb(1'b0, RESULT_BASE + 12'h4, '0);
            check(rd, 32'(held.b));
        end
        clear_check();
    endtask : one_shot
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report
    // ====
    // tests
    initial begin
        void'($urandom(32'ha67d17a1));
        repeat (20) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        apb(1'b0, CTRL1_ADDR, '0);
        check(rd, 32'(CTRL1_RESET));
        apb(1'b0, MASK_ADDR, '0);
        check(rd, 32'(MASK_RESET));
        apb(1'b0, 12'h020, '0);
        check({rd[30:0], err}, 32'h1);
        $display("test reset done");
        for (s = 0; s < 4; s++) begin
            one_shot(s, 1'b1, {1'b0, 3'($urandom)}, s[0] ? 2'b10 : 2'b01);
            $display("test pair source %0d done", s);
        end
        one_shot(0, 1'b0, {1'b1, 3'($urandom)}, 2'b01);
        $display("test single channel done");
        // free run, stopped by clearing the continuous bit mid-run
        aq = 4'($urandom);
        apb(1'b1, MASK_ADDR, 32'h0);
        apb(1'b1, CTRL1_ADDR, ctl(1'b1, 1'b1, aq, 4'h5));
        fire(0);
        wait_for(0, 1'b1, n);
        check(n, 7);
        for (k = 0; k < 3; k++) begin
            wait_for(0, 1'b0, n);
            check(n, 2 * (aq + 1));
            wait_for(0, 1'b1, n);
            check(n, k == 0 ? 10 : 7 + 2 * aq);
        end
        apb(1'b1, CTRL1_ADDR, ctl(1'b1, 1'b0, aq, 4'h5));
        rd = '1;
        for (k = 0; k < 40 && rd[8] !== 1'b0; k++) apb(1'b0, STATUS_ADDR, '0);
        check(32'({irq, rd[8], rd[1:0]}), 32'h3);
        apb(1'b1, MASK_ADDR, 32'h3);
        apb(1'b0, MASK_ADDR, '0);
        check(32'(irq), 32'h1);
        clear_check();
        $display("test continuous done");
        final_report();
    end
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        bad_count++;
        final_report();
    end
endmodule : testbench
